/* bench/lkr_ctrl_model.sv */
// System controller model: sends display groups over the serial link
`timescale 1ns/1ns
`default_nettype none
module lkr_ctrl_model (
  // Clock
  input wire logic clock,
  // Serial side
  output logic serial_chip_enable, group_loaded, duty_select,
  output logic [1:0] group_index
);
  initial begin
    serial_chip_enable = 1'b0;
    group_loaded = 1'b0;
    duty_select = 1'b0;
    group_index = 2'h0;
  end
  // Three or more set bits may hold ghost keys, so such key data is dropped
  function automatic logic keys_usable(input logic [29:0] key_bits);
    return $countones(key_bits) < 3;
  endfunction : keys_usable
  // One group per transfer; chip enable idles low and falls to end it
  task automatic xfer(input logic [1:0] idx, input logic duty);
    @(posedge clock) #1 serial_chip_enable = 1'b1;
    duty_select = duty;
    repeat (3) @(posedge clock);
    #1 group_loaded = 1'b1;
    group_index = idx;
    @(posedge clock) #1 group_loaded = 1'b0;
    group_index = ~idx; // Stale index inverted once released
    serial_chip_enable = 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask : xfer
endmodule : lkr_ctrl_model
`default_nettype wire

/* bench/lkr_reset_checker.sv */
// Port assertions of the reset control block
`timescale 1ns/1ns
`default_nettype none
module lkr_reset_checker (
  // Clock, reset and pins
  input wire logic clock, rst, supply_drop_detector, serial_chip_enable,
  // Control inputs
  input wire logic group_loaded, duty_select, timing_source_select, key_read_pending,
  // Timing pin and oscillator core
  input wire logic timing_pin_in, rc_charge, timing_pin_out,
  // Outputs
  input wire logic system_reset, display_enable, key_scan_enable, key_data_clear,
  input wire logic osc_run, ext_clock, shared_bp_as_common, display_latch_load,
  input wire logic key_request_out, key_request_oe_n, timing_pin_oe_n,
  input wire logic [3:0] seg_port_as_port,
  input wire logic [2:0] shared_scan_as_scan, scan_drive_level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------
  // Reset state, release and drive controls
  // ----------------------------
  a_reset_blanks: assert property (
    system_reset |-> !display_enable && key_data_clear && !key_scan_enable)
    else $error("reset left display or scan on");
  a_release_shows: assert property (
    $fell(system_reset) |-> display_enable && !key_data_clear) else $error("release blank");
  a_release_edge: assert property (
    $fell(system_reset) |-> !serial_chip_enable && !$past(serial_chip_enable, 3)
    && $past(serial_chip_enable, 6))
    else $error("release without chip enable fall");
  a_detect_sets: assert property (
    supply_drop_detector [*6] |=> system_reset) else $error("detector ignored");
  a_clock_held: assert property (
    system_reset |-> !osc_run && !ext_clock) else $error("clock runs in reset");
  a_latch_loads: assert property (
    group_loaded |=> display_latch_load) else $error("latch load lost");
  a_pins_low: assert property (
    system_reset |-> seg_port_as_port == 4'h0 && shared_scan_as_scan == 3'h0
    && scan_drive_level == 3'h0) else $error("pin not low in reset");
  a_bp_duty: assert property (
    !shared_bp_as_common |-> !$past(duty_select)) else $error("backplane pin function");
  a_pins_float: assert property (
    system_reset |-> timing_pin_oe_n && key_request_oe_n && !key_request_out)
    else $error("pin driven in reset");
  a_source_sel: assert property (
    osc_run |-> !ext_clock && !$past(timing_source_select)) else $error("source select");
  a_request_cause: assert property (
    !key_request_oe_n |-> $past(key_read_pending)) else $error("request without cause");
  // ----------------------------
  // Timing sources
  // ----------------------------
  a_timing_copy: assert property (
    !$past(rst) |-> timing_pin_out == $past(rc_charge)) else $error("timing drive stale");
  a_ext_gated: assert property (
    ext_clock |-> !system_reset && $past(timing_source_select)) else $error("external clock");
endmodule : lkr_reset_checker
bind lkr_reset_ctrl lkr_reset_checker i_lkr_reset_checker (.*);
`default_nettype wire

/* bench/lkr_reset_ctrl_bench.sv */
// Self-checking bench of the reset control block
`timescale 1ns/1ns
`default_nettype none
module lkr_reset_ctrl_bench;
  typedef logic [13:0] lkr_obs_t;
  localparam lkr_obs_t obs_in_reset = 14'h2980;
  logic clock = 1'b0, rst = 1'b1, supply_drop_detector = 1'b0, key_read_pending = 1'b0;
  logic timing_source_select = 1'b0, key_scan_disable = 1'b0;
  logic timing_pin_in = 1'b0, rc_charge = 1'b0;
  logic [3:0] port_select = 4'h0;
  logic [2:0] scan_select = 3'h0, scan_line_level = 3'h0;
  wire logic serial_chip_enable, group_loaded, duty_select;
  wire logic [1:0] group_index;
  logic timing_pin_out, timing_pin_oe_n, system_reset, display_enable, display_latch_load;
  logic key_scan_enable, key_data_clear, osc_run, ext_clock, shared_bp_as_common;
  logic key_request_out, key_request_oe_n;
  logic [3:0] seg_port_as_port;
  logic [2:0] shared_scan_as_scan, scan_drive_level;
  lkr_obs_t obs, last_obs;
  lkr_obs_t notes[$];
  logic [31:0] seed = 32'h0000A4C4;
  int error_cnt = 0, check_count = 0;
  lkr_reset_ctrl i_lkr_reset_ctrl (.*);
  lkr_ctrl_model i_lkr_ctrl_model (.*);
  always #20 clock = ~clock;
  // Timing sources run freely; the pin toggles slowly enough to pass the filter
  always @(posedge clock) #1 rc_charge = ~rc_charge;
  always begin
    repeat (8) @(posedge clock);
    #1 timing_pin_in = ~timing_pin_in;
  end
  // Observed outputs, one word so every change must be predicted
  assign obs = {system_reset, display_enable, key_data_clear, key_scan_enable, osc_run,
    timing_pin_oe_n, key_request_oe_n, seg_port_as_port, scan_drive_level};
  function automatic lkr_obs_t run_obs(input logic oe_n);
    return {3'b010, ~key_scan_disable, ~timing_source_select, timing_source_select, oe_n,
      port_select, scan_line_level};
  endfunction : run_obs
  // Xorshift step feeding every random control
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic chk(input lkr_obs_t seen, input lkr_obs_t want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  // Monitor: a change with no note pending is itself a mismatch
  always @(posedge clock) begin
    if (!rst && obs !== last_obs) begin
      if (notes.size() == 0) chk(obs, last_obs);
      else chk(obs, notes.pop_front());
    end
    last_obs <= obs;
  end
  // Controls change only in reset, where the outputs hide them
  task automatic run_set(input logic duty);
    int n;
    seed = xorshift(seed);
    {timing_source_select, key_scan_disable, port_select, scan_select, scan_line_level} =
      seed[11:0];
    n = duty ? 4 : 3;
    key_read_pending = 1'b1; // Pending read must stay hidden in reset
    for (int i = 0; i < n - 1; i++) i_lkr_ctrl_model.xfer(2'(i), duty);
    key_read_pending = 1'b0;
    notes.push_back(run_obs(1'b1));
    i_lkr_ctrl_model.xfer(2'(n - 1), duty);
  endtask : run_set
  task automatic pend_check;
    notes.push_back(run_obs(1'b0));
    key_read_pending = 1'b1;
    repeat (8) @(posedge clock);
    notes.push_back(run_obs(1'b1));
    #1 key_read_pending = 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask : pend_check
  task automatic final_report;
    if (notes.size() != 0) error_cnt++;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Watchdog, roughly fourteen times the expected run
  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    final_report();
  end
  // Main sequence: 1/3 duty set, key request, detector, 1/4 duty set, key request
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock) #1 chk(obs, obs_in_reset);
    chk(14'(i_lkr_ctrl_model.keys_usable(30'h00000007)), 14'h0000);
    chk(14'(i_lkr_ctrl_model.keys_usable(30'h00000041)), 14'h0001);
    run_set(1'b0);
    pend_check();
    notes.push_back(obs_in_reset);
    supply_drop_detector = 1'b1;
    repeat (8) @(posedge clock);
    #1 supply_drop_detector = 1'b0;
    repeat (8) @(posedge clock);
    #1 run_set(1'b1);
    pend_check();
    final_report();
  end
endmodule : lkr_reset_ctrl_bench
`default_nettype wire

/* logic/lkr_map.svh */
// Constants of the reset control block: group masks and reset values
`ifndef LKR_MAP_SVH
`define LKR_MAP_SVH

// ----------------------------------------------------------------
// Display data groups
// ----------------------------------------------------------------
`define LKR_GROUP_W 4
`define LKR_GROUPS_THIRD 4'h7
`define LKR_GROUPS_QUARTER 4'hF
`define LKR_GROUPS_NONE 4'h0

// ----------------------------------------------------------------
// Synchroniser channel positions and reset levels
// ----------------------------------------------------------------
`define LKR_SYNC_W 3
`define LKR_CH_DETECT 0
`define LKR_CH_CHIP_EN 1
`define LKR_CH_TIMING 2
`define LKR_SYNC_RESET 3'h1

`endif

/* logic/lkr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and fall detect
`timescale 1ns/1ns
`default_nettype none
`include "lkr_map.svh"

module lkr_pin_sync
  import lkr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Channels
  lkr_sync_if.sync chan
);

  // ----------------------------------------------------------------
  // Per channel stages
  // ----------------------------------------------------------------
  // Reset level per channel; the detector starts out seeing a drop
  localparam logic [`LKR_SYNC_W-1:0] sync_rst = `LKR_SYNC_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < `LKR_SYNC_W; gi++) begin : g_ch
      logic s1, s2, s3, lvl, fl;
      logic next_lvl, next_fl;

      // Level only moves once the second and third stages agree
      always_comb begin
        next_lvl = (s2 == s3) ? s3 : lvl;
        next_fl = lvl & ~next_lvl;
      end

      // Stage one feeds stage two only
      always_ff @(posedge clock) begin
        if (rst) begin
          s1 <= sync_rst[gi];
          s2 <= sync_rst[gi];
          s3 <= sync_rst[gi];
          lvl <= sync_rst[gi];
          fl <= 1'b0;
        end else begin
          s1 <= chan.pin[gi];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_lvl;
          fl <= next_fl;
        end
      end

      assign chan.level[gi] = lvl;
      assign chan.fall[gi] = fl;
    end
  endgenerate

endmodule : lkr_pin_sync

`default_nettype wire

/* logic/lkr_pkg.sv */
// Types of the reset control block
package lkr_pkg;

  // Reset sequencer states, Gray coded along the usual path
  typedef enum logic [1:0] {
    LKR_HELD = 2'b00,
    LKR_COLLECT = 2'b01,
    LKR_ARMED = 2'b11,
    LKR_RUN = 2'b10
  } lkr_seq_e;

  typedef logic [3:0] lkr_groups_t;

endpackage : lkr_pkg

/* logic/lkr_reset_ctrl.sv */
// System reset control of an LCD segment driver with key scan
`timescale 1ns/1ns
`default_nettype none
`include "lkr_map.svh"

module lkr_reset_ctrl
  import lkr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins from outside
  input wire logic supply_drop_detector,
  input wire logic serial_chip_enable,
  // Timing pin, three signals
  input wire logic timing_pin_in,
  output logic timing_pin_out,
  output logic timing_pin_oe_n,
  // From serial interface and control register
  input wire logic group_loaded,
  input wire logic [1:0] group_index,
  input wire logic duty_select,
  input wire logic timing_source_select,
  input wire logic key_scan_disable,
  input wire logic [3:0] port_select,
  input wire logic [2:0] scan_select,
  input wire logic [2:0] scan_line_level,
  // From oscillator core and key scan logic
  input wire logic rc_charge,
  input wire logic key_read_pending,
  // Status and drive control
  output logic system_reset,
  output logic display_enable,
  output logic display_latch_load,
  output logic key_scan_enable,
  output logic key_data_clear,
  output logic osc_run,
  output logic ext_clock,
  output logic [3:0] seg_port_as_port,
  output logic [2:0] shared_scan_as_scan,
  output logic [2:0] scan_drive_level,
  output logic shared_bp_as_common,
  output logic key_request_out,
  output logic key_request_oe_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  lkr_sync_if sync_ch ();

  assign sync_ch.pin[`LKR_CH_DETECT] = supply_drop_detector;
  assign sync_ch.pin[`LKR_CH_CHIP_EN] = serial_chip_enable;
  assign sync_ch.pin[`LKR_CH_TIMING] = timing_pin_in;

  lkr_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .chan(sync_ch)
  );

  logic drop_seen;
  logic ce_level;
  logic ce_fall;
  logic ext_level;

  assign drop_seen = sync_ch.level[`LKR_CH_DETECT];
  assign ce_level = sync_ch.level[`LKR_CH_CHIP_EN];
  assign ce_fall = sync_ch.fall[`LKR_CH_CHIP_EN];
  assign ext_level = sync_ch.level[`LKR_CH_TIMING];

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  lkr_seq_e state, next_state;
  lkr_groups_t groups, next_groups;
  lkr_groups_t groups_needed;
  logic duty_known, next_duty_known;
  logic set_complete;

  // Quarter duty needs four groups, third duty three
  always_comb begin
    groups_needed = duty_select ? `LKR_GROUPS_QUARTER : `LKR_GROUPS_THIRD;
    set_complete = ((groups | (group_loaded ? lkr_groups_t'(4'h1 << group_index)
                                            : `LKR_GROUPS_NONE))
                    & groups_needed) == groups_needed;
  end

  // Detector beats a release in the same cycle, so a droop is never lost
  always_comb begin
    next_state = state;
    next_groups = groups;
    next_duty_known = duty_known | group_loaded;
    if (group_loaded) begin
      next_groups = groups | lkr_groups_t'(4'h1 << group_index);
    end
    unique case (state)
      LKR_HELD: begin
        if (group_loaded) begin
          next_state = LKR_COLLECT;
        end
      end
      LKR_COLLECT: begin
        if (set_complete) begin
          next_state = LKR_ARMED;
        end
      end
      LKR_ARMED: begin
        if (ce_fall) begin
          next_state = LKR_RUN;
          next_groups = `LKR_GROUPS_NONE;
        end
      end
      LKR_RUN: begin
        next_groups = `LKR_GROUPS_NONE;
      end
    endcase
    if (drop_seen) begin
      next_state = LKR_HELD;
      next_groups = `LKR_GROUPS_NONE;
    end
  end

  // Power-up knowledge of duty survives a detector reset; only a full reset clears it
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= LKR_HELD;
      groups <= `LKR_GROUPS_NONE;
      duty_known <= 1'b0;
    end else begin
      state <= next_state;
      groups <= next_groups;
      duty_known <= next_duty_known;
    end
  end

  // ----------------------------------------------------------------
  // Registered drive controls
  // ----------------------------------------------------------------
  logic in_reset;
  logic next_system_reset, next_display_enable, next_latch_load;
  logic next_scan_enable, next_key_clear, next_osc_run, next_ext_clock;
  logic next_timing_out, next_timing_oe_n, next_bp_common, next_req_oe_n;
  logic [3:0] next_port;
  logic [2:0] next_shared_scan, next_scan_level;

  // Serial side inputs pass ungated, so transfers work in reset
  always_comb begin
    in_reset = (next_state != LKR_RUN);
    next_system_reset = in_reset;
    next_display_enable = ~in_reset;
    next_latch_load = group_loaded;
    next_scan_enable = ~in_reset & ~key_scan_disable;
    next_key_clear = in_reset;
    next_osc_run = ~in_reset & ~timing_source_select;
    next_ext_clock = ~in_reset & timing_source_select & ext_level;
    next_timing_out = rc_charge;
    next_timing_oe_n = in_reset | timing_source_select;
    next_port = in_reset ? 4'h0 : port_select;
    next_shared_scan = in_reset ? 3'h0 : scan_select;
    next_scan_level = in_reset ? 3'h0 : scan_line_level;
    next_bp_common = ~next_duty_known | duty_select;
    // Chip enable high also releases the line during a transfer
    next_req_oe_n = in_reset | ~key_read_pending | ce_level;
  end

  // Every output comes from a flop
  always_ff @(posedge clock) begin
    if (rst) begin
      system_reset <= 1'b1;
      display_enable <= 1'b0;
      display_latch_load <= 1'b0;
      key_scan_enable <= 1'b0;
      key_data_clear <= 1'b1;
      osc_run <= 1'b0;
      ext_clock <= 1'b0;
      timing_pin_out <= 1'b0;
      timing_pin_oe_n <= 1'b1;
      seg_port_as_port <= 4'h0;
      shared_scan_as_scan <= 3'h0;
      scan_drive_level <= 3'h0;
      shared_bp_as_common <= 1'b1;
      key_request_out <= 1'b0;
      key_request_oe_n <= 1'b1;
    end else begin
      system_reset <= next_system_reset;
      display_enable <= next_display_enable;
      display_latch_load <= next_latch_load;
      key_scan_enable <= next_scan_enable;
      key_data_clear <= next_key_clear;
      osc_run <= next_osc_run;
      ext_clock <= next_ext_clock;
      timing_pin_out <= next_timing_out;
      timing_pin_oe_n <= next_timing_oe_n;
      seg_port_as_port <= next_port;
      shared_scan_as_scan <= next_shared_scan;
      scan_drive_level <= next_scan_level;
      shared_bp_as_common <= next_bp_common;
      key_request_out <= 1'b0; // Open drain only ever pulls low
      key_request_oe_n <= next_req_oe_n;
    end
  end

endmodule : lkr_reset_ctrl

`default_nettype wire

/* logic/lkr_sync_if.sv */
// Carrier between the pin synchroniser and the reset sequencer
`timescale 1ns/1ns
`default_nettype none

interface lkr_sync_if;
  logic [2:0] pin;
  logic [2:0] level;
  logic [2:0] fall;

  modport sync (input pin, output level, output fall);
  modport user (output pin, input level, input fall);
endinterface : lkr_sync_if

`default_nettype wire
